//--- hdl/bc_condition_flag_registers.sv
// condition code, configuration and revision registers of the controller
`timescale 1ns/1ps
`include "bc_flags_map.svh"

//Contract
// - writing one to version bit 9 reads back at bits 9 and 5
// - watchdog enable and eof mask raise interrupt when frame count hits zero
// - revision register returns back-end revision, read only
// - condition word bit 15 always reads one
// - message condition bits update at message end, held until next message
// - bit 14 for two retries, bit 13 for one or two retries
// - bit 12 on loopback error, format error or no response
// - bit 11 on unmasked set status bit; broadcast mode selects testing
// - bit 10 when data block stored without error
// - bit 9 on response format error, bit 8 on no response
// - bits 7 to 2 read user flags seven to two
// - bit 1 shows flag one; compare loads it with less-than
// - bit 0 shows flag zero; compare loads it with equal
// - write ones in bits 15 to 8 clear flags seven to zero
// - write ones in bits 7 to 0 set flags seven to zero
// - clear and set of one flag in one write toggles it
// - all user flags are zero after reset
// - frame remaining counts down in 100 us units to zero
module bc_condition_flag_registers
	import bc_flags_pkg::*;
#(
	// arbitrary neutral revision value
	parameter logic [15:0] BACKEND_REV = 16'h0001,
	parameter int          TICK_CYCLES = `TICK_CYC
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// host register port
	input  wire logic [4:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata_r,
	// message results from the sequencing engine
	input  wire logic        msg_done,
	input  wire logic [1:0]  msg_retries,
	input  wire logic        msg_loop_err,
	input  wire logic        msg_fmt_err,
	input  wire logic        msg_no_resp,
	input  wire logic        msg_good_data,
	input  wire logic        msg_bcast,
	input  wire logic        bcast_test_mode,
	input  wire logic [15:0] rt_status,
	input  wire logic [15:0] rt_status_mask,
	// instruction engine flag updates
	input  wire logic [7:0]  eng_flag_set,
	input  wire logic [7:0]  eng_flag_clr,
	input  wire logic        cmp_done,
	input  wire logic        cmp_less,
	input  wire logic        cmp_equal,
	// frame timer
	input  wire logic        frame_load,
	input  wire logic [15:0] frame_time,
	input  wire logic        eof_irq_mask,
	output logic      [15:0] frame_remaining_r,
	output logic             eof_irq_r,
	// state seen by the engine
	output logic      [7:0]  user_flags_r,
	output logic             wdog_en_r
);

	// ****************************************************
	// parameter checks
	// ****************************************************
	if (TICK_CYCLES < 2 || TICK_CYCLES > 4096) begin : g_chk
		$error("TICK_CYCLES must lie in 2..4096");
	end

	localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

	state_t s_r;
	state_t s_nxt;

	logic       wr_cc;
	logic       wr_cfg;
	logic [7:0] host_flags;
	logic [7:0] flag_clr_w;
	logic [7:0] flag_set_w;
	logic       tick;
	logic       status_hit;

	assign wr_cc      = reg_wr && reg_addr == `CC_OFS;
	assign wr_cfg     = reg_wr && reg_addr == `CFG7_OFS;
	assign flag_clr_w = reg_wdata[15:`CC_CLR_LSB];
	assign flag_set_w = reg_wdata[`CC_CLR_LSB-1:0];
	assign tick       = s_r.frame_cnt != 16'h0000 && s_r.prescale == TICK_LAST;

	// ****************************************************
	// host flag write, per flag
	// ****************************************************
	for (genvar i = 0; i < 8; i++) begin : g_flag
		always_comb begin
			host_flags[i] = s_r.flags[i];
			if (wr_cc) begin
				if (flag_clr_w[i] && flag_set_w[i]) begin
					host_flags[i] = ~s_r.flags[i];
				end else if (flag_set_w[i]) begin
					host_flags[i] = 1'b1;
				end else if (flag_clr_w[i]) begin
					host_flags[i] = 1'b0;
				end
			end
		end
	end

	// status test; a broadcast has no reply to test unless mode allows it
	assign status_hit = (|(rt_status & ~rt_status_mask)) &&
		(!msg_bcast || bcast_test_mode);

	// ****************************************************
	// next state
	// ****************************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.eof_irq = 1'b0;
		s_nxt.rdata = 16'h0000;

		// configuration write
		if (wr_cfg) begin
			s_nxt.cfg_version = reg_wdata[`CFG7_VER_BIT];
			s_nxt.cfg_wdog = reg_wdata[`CFG7_WDOG_BIT];
		end

		// host flags first, engine applied over them
		s_nxt.flags = (host_flags & ~eng_flag_clr) | eng_flag_set;
		if (cmp_done) begin
			s_nxt.flags[`CC_LT_FLAG] = cmp_less;
			s_nxt.flags[`CC_EQ_FLAG] = cmp_equal;
		end

		// message conditions change only here, never on host writes
		if (msg_done) begin
			s_nxt.cond[`CC_RETRY_MSB_BIT-`CC_CLR_LSB] =
				msg_retries == `RETRY_TWO;
			s_nxt.cond[`CC_RETRY_LSB_BIT-`CC_CLR_LSB] =
				msg_retries != `RETRY_NONE;
			s_nxt.cond[`CC_ANY_ERR_BIT-`CC_CLR_LSB] =
				msg_loop_err || msg_fmt_err || msg_no_resp;
			s_nxt.cond[`CC_STATUS_BIT-`CC_CLR_LSB] = status_hit;
			s_nxt.cond[`CC_GOOD_BIT-`CC_CLR_LSB] = msg_good_data;
			s_nxt.cond[`CC_FMT_BIT-`CC_CLR_LSB] = msg_fmt_err;
			s_nxt.cond[`CC_NORESP_BIT-`CC_CLR_LSB] = msg_no_resp;
		end

		// frame timer: one count per 100 us, parked at zero
		if (frame_load) begin
			s_nxt.frame_cnt = frame_time;
			s_nxt.prescale = 12'h000;
		end else if (s_r.frame_cnt != 16'h0000) begin
			if (tick) begin
				s_nxt.prescale = 12'h000;
				s_nxt.frame_cnt = s_r.frame_cnt - 16'h0001;
			end else begin
				s_nxt.prescale = s_r.prescale + 12'h001;
			end
		end else begin
			s_nxt.prescale = 12'h000;
		end

		// end of frame interrupt is a one-cycle pulse
		if (tick && s_r.frame_cnt == 16'h0001 && s_r.cfg_wdog &&
			eof_irq_mask && !frame_load) begin
			s_nxt.eof_irq = 1'b1;
		end

		// read data lands one cycle after the read strobe
		if (reg_rd) begin
			unique case (reg_addr)
				`CFG7_OFS: begin
					s_nxt.rdata[`CFG7_VER_BIT] = s_r.cfg_version;
					s_nxt.rdata[`CFG7_VER_FB_BIT] = s_r.cfg_version;
					s_nxt.rdata[`CFG7_WDOG_BIT] = s_r.cfg_wdog;
				end
				`REV_OFS: begin
					s_nxt.rdata = BACKEND_REV;
				end
				`CC_OFS: begin
					s_nxt.rdata[`CC_ONE_BIT] = 1'b1;
					s_nxt.rdata[`CC_ONE_BIT-1:`CC_CLR_LSB] = s_r.cond;
					s_nxt.rdata[7:0] = s_r.flags;
				end
				default: begin
					s_nxt.rdata = 16'h0000;
				end
			endcase
		end
	end

	// ****************************************************
	// state register
	// ****************************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata_r       = s_r.rdata;
	assign frame_remaining_r = s_r.frame_cnt;
	assign eof_irq_r         = s_r.eof_irq;
	assign user_flags_r      = s_r.flags;
	assign wdog_en_r         = s_r.cfg_wdog;

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	ver_store_a: assert property (
		wr_cfg |=> s_r.cfg_version == $past(reg_wdata[`CFG7_VER_BIT]))
		else $error("version bit not stored");

	ver_mirror_a: assert property (
		reg_rd && reg_addr == `CFG7_OFS |=>
		reg_rdata_r[`CFG7_VER_BIT] == $past(s_r.cfg_version) &&
		reg_rdata_r[`CFG7_VER_FB_BIT] == $past(s_r.cfg_version))
		else $error("version bit not mirrored");

	eof_pulse_a: assert property (
		(tick && frame_remaining_r == 16'h0001 && wdog_en_r &&
		eof_irq_mask && !frame_load)
		|=> eof_irq_r && frame_remaining_r == 16'h0000 ##1 !eof_irq_r)
		else $error("end of frame pulse wrong");

	rev_read_a: assert property (
		reg_rd && reg_addr == `REV_OFS |=> reg_rdata_r == BACKEND_REV)
		else $error("revision read wrong");

	cc_one_a: assert property (
		reg_rd && reg_addr == `CC_OFS |=> reg_rdata_r[`CC_ONE_BIT])
		else $error("condition bit 15 not one");

	cond_hold_a: assert property (
		!msg_done |=> $stable(s_r.cond))
		else $error("condition bits moved without message");

	retry_code_a: assert property (
		msg_done |=>
		s_r.cond[6] == ($past(msg_retries) == `RETRY_TWO) &&
		s_r.cond[5] == ($past(msg_retries) != `RETRY_NONE))
		else $error("retry bits wrong");

	any_err_a: assert property (
		msg_done && (msg_loop_err || msg_fmt_err || msg_no_resp)
		|=> s_r.cond[4])
		else $error("error bit not set");

	status_set_a: assert property (
		msg_done && (|(rt_status & ~rt_status_mask)) &&
		(!msg_bcast || bcast_test_mode)
		|=> s_r.cond[`CC_STATUS_BIT-`CC_CLR_LSB])
		else $error("status bit not set");

	status_clr_a: assert property (
		msg_done && (!(|(rt_status & ~rt_status_mask)) ||
		(msg_bcast && !bcast_test_mode))
		|=> !s_r.cond[`CC_STATUS_BIT-`CC_CLR_LSB])
		else $error("status bit set wrongly");

	good_fmt_a: assert property (
		msg_done |=>
		s_r.cond[`CC_GOOD_BIT-`CC_CLR_LSB] == $past(msg_good_data) &&
		s_r.cond[`CC_FMT_BIT-`CC_CLR_LSB] == $past(msg_fmt_err) &&
		s_r.cond[`CC_NORESP_BIT-`CC_CLR_LSB] == $past(msg_no_resp))
		else $error("data or response bits wrong");

	cc_read_a: assert property (
		reg_rd && reg_addr == `CC_OFS |=>
		reg_rdata_r[`CC_CLR_LSB-1:0] == $past(user_flags_r) &&
		reg_rdata_r[`CC_ONE_BIT-1:`CC_CLR_LSB] == $past(s_r.cond))
		else $error("condition word read wrong");

	flag_set_a: assert property (
		wr_cc && flag_set_w[7] && !flag_clr_w[7] && !eng_flag_clr[7]
		|=> user_flags_r[7])
		else $error("flag seven not set");

	flag_clr_a: assert property (
		wr_cc && flag_clr_w[3] && !flag_set_w[3] && !eng_flag_set[3]
		|=> !user_flags_r[3])
		else $error("flag three not cleared");

	flag_keep_a: assert property (
		wr_cc && !flag_clr_w[5] && !flag_set_w[5] &&
		!eng_flag_set[5] && !eng_flag_clr[5]
		|=> user_flags_r[5] == $past(user_flags_r[5]))
		else $error("flag five moved on zero write");

	flags_reset_a: assert property (
		disable iff (1'b0) reset |=> user_flags_r == 8'h00)
		else $error("flags not zero after reset");

	frame_step_a: assert property (
		tick && !frame_load |=>
		frame_remaining_r == $past(frame_remaining_r) - 16'h0001)
		else $error("frame count step wrong");

	flag_toggle_a: assert property (
		wr_cc && flag_clr_w[0] && flag_set_w[0] && !cmp_done &&
		!eng_flag_set[0] && !eng_flag_clr[0]
		|=> user_flags_r[0] != $past(user_flags_r[0]))
		else $error("flag zero not toggled");

	cmp_load_a: assert property (
		cmp_done |=> user_flags_r[1:0] == $past({cmp_less, cmp_equal}))
		else $error("compare result not loaded");

	toggle_c: cover property (wr_cc && flag_clr_w[0] && flag_set_w[0]);
	eof_c:    cover property (eof_irq_r);
	retry_c:  cover property (msg_done && msg_retries == `RETRY_TWO);
	clash_c:  cover property (wr_cc && cmp_done);

endmodule : bc_condition_flag_registers

//--- hdl/bc_flags_map.svh
// register offsets, field positions and timing counts of the flag registers
`ifndef BC_FLAGS_MAP_SVH
`define BC_FLAGS_MAP_SVH

// word offsets on the local register port
`define CFG7_OFS          5'h19
`define REV_OFS           5'h1a
`define CC_OFS            5'h1b

// configuration register fields
`define CFG7_VER_BIT      9
`define CFG7_VER_FB_BIT   5
`define CFG7_WDOG_BIT     1

// condition word fields
`define CC_ONE_BIT        15
`define CC_RETRY_MSB_BIT  14
`define CC_RETRY_LSB_BIT  13
`define CC_ANY_ERR_BIT    12
`define CC_STATUS_BIT     11
`define CC_GOOD_BIT       10
`define CC_FMT_BIT        9
`define CC_NORESP_BIT     8
`define CC_CLR_LSB        8
`define CC_LT_FLAG        1
`define CC_EQ_FLAG        0

// retry counts
`define RETRY_TWO         2'h2
`define RETRY_NONE        2'h0

// frame time unit and clock
`define FRAME_UNIT_NS     100000
`define CLK_PERIOD_NS     25
`define TICK_CYC \
	((`FRAME_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- hdl/bc_flags_pkg.sv
// state type of the condition flag register group
package bc_flags_pkg;

	typedef struct packed {
		logic        cfg_version;
		logic        cfg_wdog;
		logic [7:0]  flags;
		logic [6:0]  cond;
		logic [11:0] prescale;
		logic [15:0] frame_cnt;
		logic        eof_irq;
		logic [15:0] rdata;
	} state_t;

endpackage : bc_flags_pkg

//--- dv/host_port_model.sv
// host processor model on the local register port
`timescale 1ns/1ps
module host_port_model (
	// clock
	input  wire logic        clk_sys,
	// register port
	output logic      [4:0]  reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata_r
);
	initial begin
		reg_addr  = 5'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_wdata = 16'h0000;
	end
	// released lines show the inverse, so a stale value never passes
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d; // only flags named in d are touched
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata_r;
	endtask : rd
endmodule : host_port_model

//--- dv/test_bc_condition_flag_registers.sv
// self-checking bench of the condition flag register group
`timescale 1ns/1ps
`include "bc_flags_map.svh"
module test_bc_condition_flag_registers;
	localparam logic [15:0] REV  = 16'h5a3c; // arbitrary revision value
	localparam int          TICK = 4;
	logic        clk_sys, reset, reg_wr, reg_rd, msg_done, msg_loop_err;
	logic        msg_fmt_err, msg_no_resp, msg_good_data, msg_bcast;
	logic        bcast_test_mode, cmp_done, cmp_less, cmp_equal;
	logic        frame_load, eof_irq_mask, eof_irq_r, wdog_en_r;
	logic [1:0]  msg_retries;
	logic [4:0]  reg_addr;
	logic [7:0]  eng_flag_set, eng_flag_clr, user_flags_r;
	logic [15:0] reg_wdata, reg_rdata_r, rt_status, rt_status_mask;
	logic [15:0] frame_time, frame_remaining_r, v;
	int          miscompares, comparisons, cycles;

	bc_condition_flag_registers #(.BACKEND_REV(REV), .TICK_CYCLES(TICK))
	u_dut (.clk_sys, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata_r, .msg_done, .msg_retries, .msg_loop_err, .msg_fmt_err,
		.msg_no_resp, .msg_good_data, .msg_bcast, .bcast_test_mode,
		.rt_status, .rt_status_mask, .eng_flag_set, .eng_flag_clr,
		.cmp_done, .cmp_less, .cmp_equal, .frame_load, .frame_time,
		.eof_irq_mask, .frame_remaining_r, .eof_irq_r, .user_flags_r,
		.wdog_en_r);
	host_port_model u_host (.clk_sys, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata_r);

	// ****************************************
	// checking and closing
	// ****************************************
	task automatic chk(input string n, input logic [15:0] s, e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic summarize;
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		u_host.rd(`CC_OFS, v);
		chk("cc reset", v, 16'h8000);
		u_host.wr(`CFG7_OFS, 16'h0202);
		#1 chk("wdog", 16'(wdog_en_r), 16'h0001);
		u_host.rd(`CFG7_OFS, v);
		chk("cfg7", v, 16'h0222);
		u_host.wr(`REV_OFS, 16'hffff);
		u_host.rd(`REV_OFS, v);
		chk("rev", v, REV);
	endtask : t_regs
	task automatic t_flags;
		u_host.wr(`CC_OFS, 16'h00a5);
		u_host.rd(`CC_OFS, v);
		chk("cc set", v, 16'h80a5);
		u_host.wr(`CC_OFS, 16'h0f03);
		#1 chk("flags", 16'(user_flags_r), 16'h00a2);
		@(posedge clk_sys);
		cmp_done <= 1'b1;
		{cmp_less, cmp_equal} <= 2'b11;
		@(posedge clk_sys);
		cmp_done <= 1'b0;
		#1 chk("compare", 16'(user_flags_r), 16'h00a3);
		fork
			u_host.wr(`CC_OFS, 16'h0002);
			begin
				@(posedge clk_sys);
				{eng_flag_set, eng_flag_clr} <= 16'h4002;
				@(posedge clk_sys);
				{eng_flag_set, eng_flag_clr} <= 16'h0000;
			end
		join
		#1 chk("collide", 16'(user_flags_r), 16'h00e1);
	endtask : t_flags
	task automatic send(input logic [1:0] r, input logic [4:0] e,
		input logic [15:0] x);
		@(posedge clk_sys);
		msg_done <= 1'b1;
		msg_retries <= r;
		{msg_loop_err, msg_fmt_err, msg_no_resp, msg_good_data, msg_bcast} <= e;
		@(posedge clk_sys);
		msg_done <= 1'b0;
		u_host.rd(`CC_OFS, v);
		chk("cond", v, x);
	endtask : send
	task automatic t_modes;
		@(posedge clk_sys);
		bcast_test_mode <= 1'b1;
		rt_status_mask  <= 16'h0010;
		send(2'h0, 5'b10001, 16'h9000);
		@(posedge clk_sys);
		rt_status_mask <= 16'h0000;
		send(2'h0, 5'b00011, 16'h8c00);
	endtask : t_modes
	task automatic t_frame;
		int n;
		@(posedge clk_sys);
		frame_time <= 16'h0002;
		frame_load <= 1'b1;
		@(posedge clk_sys);
		frame_load <= 1'b0;
		#1 chk("remain", frame_remaining_r, 16'h0002);
		n = 0;
		while (eof_irq_r !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk("eof delay", 16'(n), 16'(2 * TICK));
		chk("at eof", frame_remaining_r, 16'h0000);
		@(posedge clk_sys);
		#1 chk("eof pulse", 16'(eof_irq_r), 16'h0000);
		@(posedge clk_sys);
		eof_irq_mask <= 1'b0;
		frame_time   <= 16'h0001;
		frame_load   <= 1'b1;
		@(posedge clk_sys);
		frame_load <= 1'b0;
		n = 0;
		repeat (2 * TICK + 2) begin
			@(posedge clk_sys);
			#1 if (eof_irq_r === 1'b1) n++;
		end
		chk("eof masked", 16'(n), 16'h0000);
		chk("masked end", frame_remaining_r, 16'h0000);
	endtask : t_frame

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		{reset, msg_done, msg_loop_err, msg_fmt_err, msg_no_resp} = 5'h10;
		{msg_good_data, msg_bcast, bcast_test_mode, cmp_done} = 4'h0;
		{cmp_less, cmp_equal, frame_load, eof_irq_mask} = 4'h1;
		{msg_retries, eng_flag_set, eng_flag_clr} = 18'h00000;
		{rt_status, rt_status_mask, frame_time} = {16'h0010, 32'h0};
		{miscompares, comparisons, cycles} = '0;
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		t_regs();
		t_flags();
		send(2'h2, 5'b01000, 16'hfae1);
		send(2'h1, 5'b00100, 16'hb9e1);
		u_host.wr(`CC_OFS, 16'hff00);
		u_host.rd(`CC_OFS, v);
		chk("cc hold", v, 16'hb900);
		send(2'h0, 5'b00010, 16'h8c00);
		send(2'h0, 5'b00011, 16'h8400);
		t_modes();
		t_frame();
		summarize();
	end
endmodule : test_bc_condition_flag_registers
